// [design/oim_pkg.sv]
`default_nettype none
package oim_pkg;
	localparam int unsigned OIM_SPACES = 4;
	localparam logic [11:0] OIM_OFS_ADDR_LOW = 12'h08e0;
	localparam logic [11:0] OIM_OFS_ADDR_HIGH = 12'h08e4;
	localparam logic [11:0] OIM_OFS_ATTR = 12'h08ec;
	localparam int unsigned OIM_HIGH_W = 20;
	localparam logic [31:0] OIM_RESET_VAL = 32'h0000_0000;
	typedef enum logic [1:0]
	{
		OIM_SPACE_SECURE,
		OIM_SPACE_NONSECURE,
		OIM_SPACE_ROOT,
		OIM_SPACE_REALM
	} oim_space_e;
	typedef enum logic [1:0]
	{
		OIM_IDLE,
		OIM_SEND
	} oim_state_e;
endpackage
`default_nettype wire

// [design/oim_bank_if.sv]
`default_nettype none
interface oim_bank_if;
	logic wr_en;
	logic [1:0] wr_space;
	logic wr_high;
	logic [31:0] wr_data;
	logic [1:0] rd_space;
	logic [31:0] rd_low;
	logic [31:0] rd_high;
	logic [1:0] tx_space;
	logic [51:0] tx_addr;
	modport ctrl
	(
		output wr_en, wr_space, wr_high, wr_data, rd_space, tx_space,
		input rd_low, rd_high, tx_addr
	);
	modport bank
	(
		input wr_en, wr_space, wr_high, wr_data, rd_space, tx_space,
		output rd_low, rd_high, tx_addr
	);
endinterface
`default_nettype wire

// [design/oim_addr_bank.sv]
`default_nettype none
module oim_addr_bank
	import oim_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	oim_bank_if.bank bus
);
	logic [31:2] low_q [OIM_SPACES];
	logic [OIM_HIGH_W-1:0] high_q [OIM_SPACES];

	for (genvar s = 0; s < OIM_SPACES; s++)
	begin : g_space
		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				low_q[s] <= OIM_RESET_VAL[31:2];
				high_q[s] <= OIM_RESET_VAL[OIM_HIGH_W-1:0];
			end
			else if (bus.wr_en && bus.wr_space == 2'(s))
			begin
				if (bus.wr_high)
					high_q[s] <= bus.wr_data[OIM_HIGH_W-1:0];
				else
					low_q[s] <= bus.wr_data[31:2];
			end
		end
	end

	// One copy per space, selected by index
	assign bus.rd_low = {low_q[bus.rd_space], 2'b00};
	assign bus.rd_high = {12'h000, high_q[bus.rd_space]};
	// Second port for the sender, so a page read never steers it
	assign bus.tx_addr = {high_q[bus.tx_space], low_q[bus.tx_space],
		2'b00};
endmodule
`default_nettype wire

// [design/oim_regs.sv]
`default_nettype none
module oim_regs
	import oim_pkg::*;
#(
	parameter bit HAS_V1P1 = 1'b1,
	parameter bit HAS_OFLOW_MSG = 1'b1,
	parameter bit HAS_RME = 1'b1
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	// Page select: which security space's feature page is accessed
	input wire logic [1:0] page_space,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Overflow event from a monitor, tagged with its space
	input wire logic ovf_event,
	input wire logic [1:0] ovf_space,
	output logic msg_valid,
	input wire logic msg_ready,
	output logic [51:0] msg_addr,
	output logic [1:0] msg_space,
	output logic hw_ovf_irq
);
	oim_bank_if bif ();
	logic present;
	logic space_ok;
	logic [OIM_SPACES-1:0] msg_en;
	logic hit_low;
	logic hit_high;
	logic hit_attr;
	logic take_event;
	logic launch;
	oim_state_e state;

	oim_addr_bank u_bank
	(
		.mclk(mclk),
		.sys_rst(sys_rst),
		.bus(bif.bank)
	);

	// Registers and messages vanish without both feature and capability; the hardwired line still follows ovf_event
	assign present = HAS_V1P1 && HAS_OFLOW_MSG;
	// Root and realm pages only live with realm management
	assign space_ok = (page_space == OIM_SPACE_SECURE) ||
		(page_space == OIM_SPACE_NONSECURE) || HAS_RME;
	assign hit_low = present && space_ok &&
		reg_addr == OIM_OFS_ADDR_LOW;
	assign hit_high = present && space_ok &&
		reg_addr == OIM_OFS_ADDR_HIGH;
	assign hit_attr = present && space_ok && reg_addr == OIM_OFS_ATTR;

	assign bif.wr_en = reg_wr && (hit_low || hit_high);
	assign bif.wr_space = page_space;
	assign bif.wr_high = hit_high;
	assign bif.wr_data = reg_wdata;
	// Separate ports keep page reads clear of a pending send
	assign bif.rd_space = page_space;
	assign bif.tx_space = msg_space;
	assign take_event = ovf_event && present && msg_en[ovf_space];
	assign launch = state == OIM_SEND && !msg_valid && msg_en[msg_space];

	// Enable bit of the attribute register, per space
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			msg_en <= '0;
		else if (reg_wr && hit_attr)
			msg_en[page_space] <= reg_wdata[0];
	end

	// Read data registered; unmapped or absent reads zero
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= OIM_RESET_VAL;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (!reg_rd)
				reg_rdata <= OIM_RESET_VAL;
			else if (hit_low)
				reg_rdata <= bif.rd_low;
			else if (hit_high)
				reg_rdata <= bif.rd_high;
			else if (hit_attr)
				reg_rdata <= {31'h0, msg_en[page_space]};
			else
				reg_rdata <= OIM_RESET_VAL;
		end
	end

	// Send state; events during a send are dropped (no queue)
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			state <= OIM_IDLE;
		else
		begin
			unique case (state)
				OIM_IDLE:
				begin
					if (take_event)
						state <= OIM_SEND;
				end
				OIM_SEND:
				begin
					// Enable cleared before launch cancels the send
					if (!msg_valid && !msg_en[msg_space])
						state <= OIM_IDLE;
					else if (msg_valid && msg_ready)
						state <= OIM_IDLE;
				end
				default:
					state <= OIM_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			msg_space <= OIM_SPACE_SECURE;
		else if (state == OIM_IDLE && take_event)
			msg_space <= ovf_space;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			msg_valid <= 1'b0;
		else if (launch)
			msg_valid <= 1'b1;
		else if (msg_valid && msg_ready)
			msg_valid <= 1'b0;
	end

	// Captured once, so a later register write cannot tear it
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			msg_addr <= '0;
		else if (launch)
			msg_addr <= bif.tx_addr;
	end

	// Hardwired line suppressed while messages are enabled
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			hw_ovf_irq <= 1'b0;
		else
			hw_ovf_irq <= ovf_event && !(present && msg_en[ovf_space]);
	end

	low_bits_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && hit_low |=> reg_rdata[1:0] == 2'b00)
		else $error("low register bits 1:0 not zero");
	high_rsvd_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && hit_high |=> reg_rdata[31:20] == 12'h000)
		else $error("high register reserved bits not zero");
	absent_reads_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && !(hit_low || hit_high || hit_attr) |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	idle_read_zero_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!reg_rd |=> !reg_rvalid && reg_rdata == '0)
		else $error("read data without a read");
	msg_needs_en_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$rose(msg_valid) |-> $past(msg_en[msg_space]))
		else $error("message issued while disabled");
	hw_suppress_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf_event && msg_en[ovf_space] |=> !hw_ovf_irq)
		else $error("hardwired irq not suppressed");
	hw_raise_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		ovf_event && !msg_en[ovf_space] |=> hw_ovf_irq)
		else $error("hardwired irq missing while disabled");
	msg_addr_form_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$rose(msg_valid) |-> msg_addr ==
		{$past(u_bank.high_q[msg_space]), $past(u_bank.low_q[msg_space]),
		2'b00})
		else $error("message address misformed");
	msg_hold_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		msg_valid && !msg_ready |=>
		msg_valid && $stable(msg_addr) && $stable(msg_space))
		else $error("pending message changed");
	rme_gate_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!HAS_RME && page_space[1] |-> !bif.wr_en)
		else $error("root or realm write without realm management");
	low_decode_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_wr && hit_low |=>
		u_bank.low_q[$past(page_space)] == $past(reg_wdata[31:2]))
		else $error("low register write missed");
	high_decode_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_wr && hit_high |=>
		u_bank.high_q[$past(page_space)] == $past(reg_wdata[19:0]))
		else $error("high register write missed");
	low_copy_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && hit_low |=>
		reg_rdata[31:2] == $past(u_bank.low_q[page_space]))
		else $error("low read from wrong copy");
	high_copy_a: assert property (
		@(posedge mclk) disable iff (sys_rst)
		reg_rd && hit_high |=>
		reg_rdata[19:0] == $past(u_bank.high_q[page_space]))
		else $error("high read from wrong copy");
endmodule
`default_nettype wire

// [tb/oim_msg_sink.sv]
`default_nettype none
module oim_msg_sink
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic stall,
	input wire logic msg_valid,
	output logic msg_ready,
	input wire logic [51:0] msg_addr,
	input wire logic [1:0] msg_space,
	output logic [53:0] got,
	output int got_count
);
	timeunit 1ns;
	timeprecision 1ns;
	// Ready only as a one-cycle pulse, so a stuck valid shows up
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			msg_ready <= 1'h0;
			got_count <= 0;
		end
		else
		begin
			msg_ready <= msg_valid && !stall && !msg_ready;
			if (msg_valid && msg_ready)
			begin
				got <= {msg_space, msg_addr};
				got_count <= got_count + 1;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import oim_pkg::*;
	logic mclk, sys_rst, reg_wr, reg_rd, reg_rvalid, ovf_event, stall;
	logic msg_valid, msg_ready, hw_ovf_irq;
	logic [1:0] page_space, ovf_space, msg_space;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed = 32'h0000_9776;
	logic [51:0] msg_addr;
	logic [53:0] got;
	logic [53:0] exp_q [$];
	logic [31:0] lo [4], hi [4];
	int bad_count, samples_checked, got_count, n;
	oim_regs uut (.mclk(mclk), .sys_rst(sys_rst), .page_space(page_space),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .ovf_event(ovf_event),
		.ovf_space(ovf_space), .msg_valid(msg_valid),
		.msg_ready(msg_ready), .msg_addr(msg_addr),
		.msg_space(msg_space), .hw_ovf_irq(hw_ovf_irq));
	oim_msg_sink sink (.mclk(mclk), .sys_rst(sys_rst), .stall(stall),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
		.msg_space(msg_space), .got(got), .got_count(got_count));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge mclk);
		{page_space, reg_addr, reg_wdata, reg_wr} = {s, a, d, 1'h1};
		@(negedge mclk);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [1:0] s, input logic [11:0] a,
		input logic [31:0] e);
		@(negedge mclk);
		{page_space, reg_addr, reg_rd} = {s, a, 1'h1};
		@(negedge mclk);
		reg_rd = 1'h0;
		chk({reg_rvalid, reg_rdata}, {1'h1, e});
	endtask
	task automatic ev(input logic [1:0] s);
		@(negedge mclk);
		{ovf_space, ovf_event} = {s, 1'h1};
		@(negedge mclk);
		ovf_event = 1'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		bad_count++;
		give_verdict();
	end
	initial
	begin
		{sys_rst, reg_wr, reg_rd, ovf_event, stall} = 5'h10;
		{page_space, ovf_space, reg_addr, reg_wdata} = 48'h0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'h0;
		for (int s = 0; s < 4; s++)
		begin
			lo[s] = rnd();
			hi[s] = rnd();
			wr(s, OIM_OFS_ADDR_LOW, lo[s]);
			wr(s, OIM_OFS_ADDR_HIGH, hi[s]);
		end
		for (int s = 0; s < 4; s++)
		begin
			rd(s, OIM_OFS_ADDR_LOW, lo[s] & 32'hffff_fffc);
			rd(s, OIM_OFS_ADDR_HIGH, hi[s] & 32'h000f_ffff);
		end
		rd(0, 12'h08e8, 32'h0000_0000);
		$display("register test done");
		for (int s = 0; s < 4; s++)
		begin
			wr(s, OIM_OFS_ATTR, 32'h0000_0001);
			exp_q.push_back({s[1:0], hi[s][19:0], lo[s][31:2], 2'h0});
			n = got_count;
			ev(s);
			chk(hw_ovf_irq, 1'h0);
			for (int i = 0; i < 40 && got_count == n; i++)
			begin
				@(negedge mclk);
				stall = rnd() > 32'h7fff_ffff;
			end
			stall = 1'h0;
			chk(got, exp_q.pop_front());
		end
		wr(1, OIM_OFS_ATTR, 32'h0000_0000);
		n = got_count;
		ev(1);
		chk(hw_ovf_irq, 1'h1);
		repeat (4) @(negedge mclk);
		chk(got_count - n, 0);
		$display("message test done");
		@(negedge mclk);
		sys_rst = 1'h1;
		repeat (2) @(negedge mclk);
		sys_rst = 1'h0;
		rd(0, OIM_OFS_ATTR, 32'h0000_0000);
		rd(2, OIM_OFS_ADDR_LOW, 32'h0000_0000);
		rd(3, OIM_OFS_ADDR_HIGH, 32'h0000_0000);
		$display("reset test done");
		give_verdict();
	end
endmodule
`default_nettype wire
